/* File: logic/axis_pulse_drive_profiler.sv */
// one axis drive profile generator: fixed and continuous pulse drive
// Behaviour
// [RQ1] fixed drive command emits exactly the loaded pulse count unaided
// [RQ2] count accel pulses, decelerate when remaining reaches it, end at last pulse
// [RQ3] host loads range, accel, initial, drive speed, count for linear fixed drive
// [RQ4] new count taken while driving; larger extends, smaller stops at once
// [RQ5] count change in S-curve may cut deceleration shape short
// [RQ6] host sets manual decel select and loads point with command 07h
// [RQ7] drive speed rewritable in linear or constant fixed drive
// [RQ8] drive speed changes ignored during S-curve fixed drive
// [RQ9] offset moves auto decel start earlier by its signed value
// [RQ10] acceleration counter offset is 8 after reset
// [RQ11] continuous drive runs until stop command or enabled stop input
// [RQ12] drive speed changes followed at any time in continuous drive
// [RQ13] decelerating stop and sudden stop commands
// [RQ14] three stop inputs with enable and level; accel drive decelerates on them
// [RQ15] constant-speed continuous drive stops at once on a stop input
// [RQ16] system wires Z-phase to input two, home one, near home zero
// [RQ17] host loads range, accel, speeds for accel continuous drive
// [RQ18] fixed or continuous command in either direction starts driving
// [RQ19] drive speed not above initial speed gives constant speed
// [RQ20] host should use low constant speed for sudden home stops
// [RQ21] separate decel enable uses the loaded deceleration value
// [RQ22] remaining counter decremented per pulse, compared with accel count plus offset
`timescale 1ns/10ps
`default_nettype none
module axis_pulse_drive_profiler import apd_pkg::*; (
    // clock and reset
    input  wire logic           mclk_i,
    input  wire logic           nrst_i,
    // command strobe
    input  wire logic           cmd_valid_i,
    input  wire logic [3:0]     cmd_i,
    // parameters
    input  wire logic [2:0]     accel_mode_register_i,
    input  wire logic [SPW-1:0] accel_i,
    input  wire logic [SPW-1:0] decel_i,
    input  wire logic [SPW-1:0] initial_speed_param_i,
    input  wire logic [SPW-1:0] drive_speed_i,
    input  wire logic           drive_speed_wr_i,
    input  wire logic [PW-1:0]  pulse_count_i,
    input  wire logic           pulse_count_wr_i,
    input  wire logic [PW-1:0]  decel_point_i,
    input  wire logic [15:0]    offset_i,
    input  wire logic           offset_wr_i,
    input  wire logic [5:0]     input_stop_mode_register_i,
    // stop pins from the motor side
    input  wire logic           zphase_stop_input_i,
    input  wire logic           home_stop_input_i,
    input  wire logic           near_home_stop_input_i,
    // drive outputs
    output logic                pulse_o,
    output logic                dir_o,
    // status
    output logic                busy_o,
    output logic [SPW-1:0]      cur_speed_o,
    output logic [PW-1:0]       remain_o
);
    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    logic [2:0] pin_meta_ff;
    logic [2:0] pin_ff;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 3'b111;
            pin_ff      <= 3'b111;
        end else begin
            pin_meta_ff <= {zphase_stop_input_i, home_stop_input_i, near_home_stop_input_i};
            pin_ff      <= pin_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        drv_state_t     st;
        logic           fixed;
        logic           dir;
        logic           dec_stop;
        logic           manual;
        logic           scurve;
        logic [SPW-1:0] speed;
        logic [SPW-1:0] target;
        logic [PW-1:0]  remain;
        logic [PW-1:0]  acc_pulses;
        logic [PW-1:0]  dec_point;
        logic [15:0]    offset;
        logic [6:0]     tick;
        logic           pulse;
    } drv_t;
    drv_t s_ff, nxt_s;

    logic step;
    apd_rate_gen u_rate (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .run_i   (s_ff.st != ST_IDLE),
        .speed_i (s_ff.speed),
        .step_o  (step)
    );

    // stop input active: enable bit 2k, active-high bit 2k+1
    function automatic logic stop_hit(input logic [2:0] pins, input logic [5:0] mode);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (mode[2*k] && (pins[k] == mode[2*k+1])) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic           hit;
    logic           tick_en;
    logic [PW:0]    thr;
    logic [SPW-1:0] dec_rate;
    assign hit      = stop_hit(pin_ff, input_stop_mode_register_i);
    assign tick_en  = (s_ff.tick == TICK_LAST);
    assign dec_rate = accel_mode_register_i[AM_SEPDEC] ? decel_i : accel_i; // RQ21
    // accel pulses plus signed offset, decel starts earlier by it
    assign thr = {1'b0, s_ff.acc_pulses} + {{(PW-15){s_ff.offset[15]}}, s_ff.offset}; // RQ9 RQ22

    // ------------------------------------------------------------
    // profile sequencing
    // ------------------------------------------------------------
    always_comb begin
        logic decel_now;
        decel_now = 1'b0;
        nxt_s = s_ff;
        nxt_s.pulse = 1'b0;
        nxt_s.tick = tick_en ? 7'h00 : 7'(s_ff.tick + 7'h01);
        if (offset_wr_i) begin
            nxt_s.offset = offset_i;
        end
        if (cmd_valid_i && cmd_i == CMD_DECPT) begin
            nxt_s.dec_point = decel_point_i;    // RQ6
        end
        if (s_ff.st == ST_IDLE) begin
            if (cmd_valid_i && (cmd_i == CMD_FIX_POS || cmd_i == CMD_FIX_NEG ||
                                cmd_i == CMD_CON_POS || cmd_i == CMD_CON_NEG)) begin
                nxt_s.tick = 7'h00;             // RQ18
                nxt_s.fixed      = (cmd_i == CMD_FIX_POS || cmd_i == CMD_FIX_NEG);
                nxt_s.dir        = (cmd_i == CMD_FIX_NEG || cmd_i == CMD_CON_NEG);
                nxt_s.remain     = pulse_count_i; // RQ1
                nxt_s.acc_pulses = '0;
                nxt_s.dec_stop   = 1'b0;
                nxt_s.manual     = accel_mode_register_i[AM_MANUAL_DECEL_SELECT];
                nxt_s.scurve     = accel_mode_register_i[AM_SCURVE];
                nxt_s.speed      = initial_speed_param_i;
                nxt_s.target     = drive_speed_i;
                // constant speed when drive not above initial
                nxt_s.st = (drive_speed_i <= initial_speed_param_i) ? ST_CONST : ST_ACCEL; // RQ19
                if (nxt_s.fixed && pulse_count_i == '0) begin
                    nxt_s.st = ST_IDLE;
                end
            end
        end else begin
            // drive speed rewrite, frozen in S-curve fixed drive
            if (drive_speed_wr_i && !(s_ff.fixed && s_ff.scurve)) begin
                nxt_s.target = drive_speed_i;   // RQ7 RQ8 RQ12
                if (s_ff.st == ST_CONST && drive_speed_i > s_ff.speed) begin
                    nxt_s.st = ST_ACCEL;
                end
            end
            // new count: larger extends, smaller ends at once
            if (s_ff.fixed && pulse_count_wr_i) begin
                nxt_s.remain = pulse_count_i;   // RQ4 RQ5
            end
            // per pulse bookkeeping
            if (step) begin
                nxt_s.pulse = 1'b1;
                if (s_ff.fixed) begin
                    nxt_s.remain = s_ff.remain - 32'h1; // RQ22
                end
                if (s_ff.st == ST_ACCEL) begin
                    nxt_s.acc_pulses = s_ff.acc_pulses + 32'h1; // RQ2
                end
            end
            if (s_ff.fixed && (s_ff.st == ST_ACCEL ||
                               (s_ff.st == ST_CONST && s_ff.speed > initial_speed_param_i))) begin
                decel_now = s_ff.manual ? (s_ff.remain <= s_ff.dec_point)
                                        : ({1'b0, s_ff.remain} <= thr); // RQ2 RQ9
            end
            if (s_ff.dec_stop || decel_now) begin
                nxt_s.st = ST_DECEL;
            end
            // speed ramp on the slow tick
            if (tick_en) begin
                unique case (s_ff.st)
                    ST_ACCEL: begin
                        if ({1'b0, s_ff.speed} + {1'b0, accel_i} >= {1'b0, s_ff.target}) begin
                            nxt_s.speed = s_ff.target;
                            if (!(s_ff.dec_stop || decel_now)) nxt_s.st = ST_CONST;
                        end else begin
                            nxt_s.speed = s_ff.speed + accel_i;
                        end
                    end
                    ST_CONST: begin
                        if (s_ff.speed > s_ff.target) begin
                            nxt_s.speed = s_ff.target;
                        end
                    end
                    ST_DECEL: begin
                        if ({1'b0, s_ff.speed} <= {1'b0, initial_speed_param_i} + {1'b0, dec_rate}) begin
                            nxt_s.speed = initial_speed_param_i; // creep at initial speed
                        end else begin
                            nxt_s.speed = s_ff.speed - dec_rate; // RQ21
                        end
                        if ((!s_ff.fixed || s_ff.dec_stop) && nxt_s.speed == initial_speed_param_i) begin
                            nxt_s.st = ST_IDLE;
                        end
                    end
                    ST_IDLE: nxt_s.speed = s_ff.speed;
                endcase
            end
            // stop commands
            if (cmd_valid_i && cmd_i == CMD_DEC_STP) begin
                nxt_s.dec_stop = 1'b1;          // RQ13
                if (s_ff.st == ST_CONST && s_ff.speed <= initial_speed_param_i) nxt_s.st = ST_IDLE;
            end
            // external stop in continuous drive
            if (!s_ff.fixed && hit) begin
                if (s_ff.st == ST_CONST && s_ff.speed <= initial_speed_param_i) begin
                    nxt_s.st = ST_IDLE;         // RQ15
                end else begin
                    nxt_s.dec_stop = 1'b1;      // RQ14 RQ11
                end
            end
            // fixed drive ends with last pulse or shrunk count
            if (s_ff.fixed && (nxt_s.remain == '0 ||
                               (pulse_count_wr_i && pulse_count_i < s_ff.remain))) begin
                nxt_s.st = ST_IDLE;             // RQ1 RQ4
            end
            if (cmd_valid_i && cmd_i == CMD_SUD_STP) begin
                nxt_s.st = ST_IDLE;             // RQ13
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_ff        <= '0;
            s_ff.st     <= ST_IDLE;
            s_ff.offset <= OFFSET_RST;          // RQ10
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pulse_o     = s_ff.pulse;
    assign dir_o       = s_ff.dir;
    assign busy_o      = (s_ff.st != ST_IDLE);
    assign cur_speed_o = s_ff.speed;
    assign remain_o    = s_ff.remain;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_OFFSET_RESET: assert property (@(posedge mclk_i) $rose(rst_n) |-> s_ff.offset == OFFSET_RST) // RQ10
        else $error("offset not 8 after reset");
    AST_SUDDEN_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (busy_o && cmd_valid_i && cmd_i == CMD_SUD_STP) |=> !busy_o) // RQ13
        else $error("sudden stop did not halt");
    AST_REMAIN_DEC: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (busy_o && s_ff.fixed && step && !pulse_count_wr_i) |=> remain_o == $past(remain_o) - 32'h1) // RQ22
        else $error("remaining count not decremented");
    AST_FIXED_END: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (busy_o && s_ff.fixed && remain_o == 32'h1 && step && !cmd_valid_i && !pulse_count_wr_i)
        |=> !busy_o) // RQ1
        else $error("fixed drive ran past last pulse");
    AST_SCURVE_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (busy_o && s_ff.fixed && s_ff.scurve) |=> s_ff.target == $past(s_ff.target)) // RQ8
        else $error("speed changed in S-curve fixed drive");
    AST_CONST_START: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (!busy_o && cmd_valid_i && cmd_i == CMD_CON_POS && drive_speed_i <= initial_speed_param_i)
        |=> s_ff.st == ST_CONST) // RQ19
        else $error("constant speed not selected");
    AST_EXT_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (busy_o && !s_ff.fixed && hit && s_ff.st == ST_ACCEL && !cmd_valid_i) |=> s_ff.dec_stop) // RQ14
        else $error("stop input did not request decelerating stop");
    AST_DIR: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (!busy_o && cmd_valid_i && cmd_i == CMD_FIX_NEG && pulse_count_i != 32'h0) |=> dir_o && busy_o) // RQ18
        else $error("negative fixed drive not started");
endmodule // axis_pulse_drive_profiler
`default_nettype wire

/* File: logic/apd_pkg.sv */
// shared constants for the axis pulse drive profiler
package apd_pkg;
    localparam int          PW          = 32;               // pulse count width
    localparam int          SPW         = 16;               // speed / rate width
    localparam int          ACCW        = 24;               // rate accumulator width
    localparam logic [15:0] OFFSET_RST  = 16'h0008;         // accel counter offset after reset
    localparam logic [ACCW-1:0] ACC_MAX = 24'hFFFFFF;       // phase accumulator full scale
    localparam int          TICK_DIV    = 100;              // speed update tick divider
    localparam logic [6:0]  TICK_LAST   = 7'(TICK_DIV - 1);
    // commands
    localparam logic [3:0]  CMD_NONE    = 4'h0;
    localparam logic [3:0]  CMD_FIX_POS = 4'h1;
    localparam logic [3:0]  CMD_FIX_NEG = 4'h2;
    localparam logic [3:0]  CMD_CON_POS = 4'h3;
    localparam logic [3:0]  CMD_CON_NEG = 4'h4;
    localparam logic [3:0]  CMD_DEC_STP = 4'h5;
    localparam logic [3:0]  CMD_SUD_STP = 4'h6;
    localparam logic [3:0]  CMD_DECPT   = 4'h7;             // load manual decel point
    // accel mode register bits
    localparam int          AM_MANUAL_DECEL_SELECT    = 0;
    localparam int          AM_SEPDEC   = 1;
    localparam int          AM_SCURVE   = 2;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ACCEL = 2'b01,
        ST_CONST = 2'b10,
        ST_DECEL = 2'b11
    } drv_state_t;
endpackage

/* File: logic/apd_rate_gen.sv */
// phase accumulator turning a speed into one-cycle step enables
`timescale 1ns/10ps
`default_nettype none
module apd_rate_gen import apd_pkg::*; (
    // clock and reset
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    // control
    input  wire logic           run_i,
    input  wire logic [SPW-1:0] speed_i,
    // step
    output logic                step_o
);
    typedef struct packed {
        logic [ACCW:0] acc;
        logic          step;
    } rg_state_t;
    rg_state_t s_ff, nxt_s;

    // accumulate speed; carry out is one step
    always_comb begin
        nxt_s = s_ff;
        nxt_s.step = 1'b0;
        if (!run_i) begin
            nxt_s.acc = '0;
        end else begin
            nxt_s.acc = {1'b0, s_ff.acc[ACCW-1:0]} + {{(ACCW+1-SPW){1'b0}}, speed_i};
            nxt_s.step = nxt_s.acc[ACCW];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
    assign step_o = s_ff.step;
endmodule // apd_rate_gen
`default_nettype wire

/* File: verif/apd_motor_model.sv */
// motor driver and sensor stand-in for the drive profiler bench
`timescale 1ns/10ps
`default_nettype none
module apd_motor_model (
    // clock and bench control
    input  wire logic        mclk_i,
    input  wire logic        clr_i,
    input  wire logic [2:0]  hit_i,
    input  wire logic [2:0]  lvl_i,
    // drive pulses from the profiler
    input  wire logic        pulse_i,
    input  wire logic        dir_i,
    // sensor pins
    output logic             zphase_o,
    output logic             home_o,
    output logic             near_home_o,
    // observation
    output logic [31:0]      cnt_o,
    output logic             last_dir_o
);
    // ----------------------------------------
    // pulse counting
    // ----------------------------------------
    // counter cleared by the bench whenever it loads a profile, so the sudden stop drive starts uncleared
    always_ff @(posedge mclk_i) begin
        if (clr_i) begin
            cnt_o <= 32'h0;
        end else if (pulse_i) begin
            cnt_o      <= cnt_o + 32'h1;
            last_dir_o <= dir_i;
        end
    end
    // ----------------------------------------
    // sensors
    // ----------------------------------------
    // a sensor shows its active level only while hit, otherwise the inverse
    assign zphase_o    = hit_i[2] ? lvl_i[2] : ~lvl_i[2];
    assign home_o      = hit_i[1] ? lvl_i[1] : ~lvl_i[1];
    assign near_home_o = hit_i[0] ? lvl_i[0] : ~lvl_i[0];
endmodule // apd_motor_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the axis pulse drive profiler
`timescale 1ns/10ps
`default_nettype none
module tb import apd_pkg::*;;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic            mclk, nrst, cmd_valid, dsp_wr, pc_wr, ofs_wr, clr;
    logic [3:0]      cmd;
    logic [2:0]      am, hit, lvl;
    logic [SPW-1:0]  acc, dec, isp, dsp, cur_speed;
    logic [PW-1:0]   pc, dpt, remain;
    logic [15:0]     ofs;
    logic [5:0]      ism;
    logic            zp, hm, nh, pulse, dir, busy, mdir;
    logic [31:0]     mcnt, seed, snap;
    int              error_cnt, cmp_count, i, k, n;

    axis_pulse_drive_profiler i_dut (
        .mclk_i(mclk), .nrst_i(nrst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
        .accel_mode_register_i(am), .accel_i(acc), .decel_i(dec), .initial_speed_param_i(isp),
        .drive_speed_i(dsp), .drive_speed_wr_i(dsp_wr), .pulse_count_i(pc), .pulse_count_wr_i(pc_wr),
        .decel_point_i(dpt), .offset_i(ofs), .offset_wr_i(ofs_wr), .input_stop_mode_register_i(ism),
        .zphase_stop_input_i(zp), .home_stop_input_i(hm), .near_home_stop_input_i(nh),
        .pulse_o(pulse), .dir_o(dir), .busy_o(busy), .cur_speed_o(cur_speed), .remain_o(remain));

    apd_motor_model i_motor (
        .mclk_i(mclk), .clr_i(clr), .hit_i(hit), .lvl_i(lvl), .pulse_i(pulse), .dir_i(dir),
        .zphase_o(zp), .home_o(hm), .near_home_o(nh), .cnt_o(mcnt), .last_dir_o(mdir));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk_bit(input logic e, input logic a);
        cmp_count++;
        if (a !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic chk_word(input logic [31:0] e, input logic [31:0] a);
        cmp_count++;
        if (a !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge mclk);
    endtask
    // one-cycle strobes, all inputs change on the falling edge
    task automatic issue(input logic [3:0] c);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd = c;
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask
    task automatic wr(input int sel, input logic [31:0] v);
        @(negedge mclk);
        if (sel == 0) dsp = v[15:0];
        if (sel == 1) pc = v;
        if (sel == 2) ofs = v[15:0];
        dsp_wr = (sel == 0);
        pc_wr = (sel == 1);
        ofs_wr = (sel == 2);
        @(negedge mclk);
        {dsp_wr, pc_wr, ofs_wr} = 3'h0;
    endtask
    // bounded wait for the drive to finish
    task automatic wait_idle(input int lim);
        n = 0;
        while (busy !== 1'b0 && n < lim) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk); // a pulse launched with the last edge still has to reach the model
    endtask
    task automatic prof(input logic [15:0] s0, input logic [15:0] s1, input logic [15:0] a, input logic [2:0] m);
        @(negedge mclk);
        {isp, dsp, acc, am, clr} = {s0, s1, a, m, 1'b1};
        @(negedge mclk);
        clr = 1'b0;
    endtask
    task automatic fixed(input logic [3:0] c, input logic [31:0] cnt, input int lim);
        pc = cnt;
        issue(c);
        cyc(1);
        chk_bit(1'b1, busy);
        wait_idle(lim);
        chk_bit(1'b0, busy);
        chk_word(cnt, mcnt);
        chk_word(32'h0, remain);
        chk_bit(c == CMD_FIX_NEG, mdir);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // watchdog sized well above the expected run of about 52k cycles
    initial begin
        #800000;
        error_cnt++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, 1'b0, 1'b1);
        summarize();
    end
    initial begin
        {nrst, cmd_valid, dsp_wr, pc_wr, ofs_wr, clr, cmd, am, hit, lvl} = '0;
        {acc, isp, dsp, pc, dpt, ofs, ism} = '0;
        dec = 16'h3000;
        seed = 32'h0000002A;
        cyc(4);
        nrst = 1'b1;
        cyc(5);
        chk_bit(1'b0, busy);
        // every accel mode, alternating direction, random count and start speed
        for (i = 0; i < 4; i++) begin
            n = 3 + int'(rnd() % 6);
            k = n;
            prof(16'h8000 + 16'(rnd() & 32'hFFF), 16'hFFFF, 16'h2000, (i == 0) ? 3'h0 : 3'(1 << (i - 1)));
            dpt = 32'(k / 2);
            if (i == 1) issue(CMD_DECPT);
            if (i == 2) wr(2, 32'h0010);
            fixed(i[0] ? CMD_FIX_NEG : CMD_FIX_POS, 32'(k), 8000);
        end
        // zero count is refused
        pc = 32'h0;
        issue(CMD_FIX_POS);
        cyc(2);
        chk_bit(1'b0, busy);
        // flat profile: a larger count extends the drive
        prof(16'hFFFF, 16'hFFFF, 16'h0000, 3'h0);
        pc = 32'h00000003;
        issue(CMD_FIX_POS);
        wr(1, 32'h00000006);
        wait_idle(3000);
        chk_word(32'h00000006, mcnt);
        // a smaller count cuts the drive short
        prof(16'hFFFF, 16'hFFFF, 16'h0000, 3'h0);
        pc = 32'h0000000A;
        issue(CMD_FIX_POS);
        cyc(600);
        chk_word(32'h0000FFFF, 32'(cur_speed));
        wr(1, 32'h00000001);
        wait_idle(4);
        chk_bit(1'b0, busy);
        snap = mcnt;
        cyc(300);
        chk_word(snap, mcnt);
        // stop pins at constant speed: disabled pin ignored, enabled pin stops at once
        for (k = 0; k < 3; k++) begin
            lvl = 3'(rnd());
            ism = 6'({lvl[k], 1'b1}) << (2 * k);
            prof(16'hFFFF, 16'hFFFF, 16'h0000, 3'h0);
            issue(k[0] ? CMD_CON_NEG : CMD_CON_POS);
            cyc(600);
            chk_bit(1'b1, mcnt != 32'h0);
            hit[(k + 1) % 3] = 1'b1;
            cyc(10);
            chk_bit(1'b1, busy);
            hit[k] = 1'b1;
            wait_idle(8);
            chk_bit(1'b0, busy);
            hit = 3'h0;
        end
        // sudden stop command
        ism = 6'h00;
        issue(CMD_CON_POS);
        cyc(600);
        issue(CMD_SUD_STP);
        wait_idle(4);
        chk_bit(1'b0, busy);
        snap = mcnt;
        cyc(300);
        chk_word(snap, mcnt);
        // ramped continuous drive: speed change followed, pin gives decelerating stop
        lvl = 3'b010;
        ism = 6'b001100;
        prof(16'h8000, 16'hFFFF, 16'h0800, 3'h0);
        issue(CMD_CON_NEG);
        cyc(2000);
        wr(0, 32'h0000F000);
        cyc(300);
        chk_word(32'h0000F000, 32'(cur_speed));
        hit[1] = 1'b1;
        cyc(10);
        chk_bit(1'b1, busy);
        wait_idle(3000);
        chk_bit(1'b0, busy);
        hit = 3'h0;
        // pin while still accelerating also gives a decelerating stop
        prof(16'h8000, 16'hFFFF, 16'h0800, 3'h0);
        issue(CMD_CON_POS);
        cyc(300);
        hit[1] = 1'b1;
        cyc(10);
        chk_bit(1'b1, busy);
        wait_idle(3000);
        chk_bit(1'b0, busy);
        hit = 3'h0;
        // decelerating stop command
        ism = 6'h00;
        prof(16'h8000, 16'hFFFF, 16'h0800, 3'h0);
        issue(CMD_CON_POS);
        cyc(2000);
        issue(CMD_DEC_STP);
        cyc(10);
        chk_bit(1'b1, busy);
        wait_idle(3000);
        chk_bit(1'b0, busy);
        // speed rewrite in fixed drive: taken in linear mode, ignored in S-curve
        for (i = 0; i < 2; i++) begin
            prof(16'h8000, 16'hC000, 16'h1000, i[0] ? 3'h4 : 3'h0);
            pc = 32'h00000028;
            issue(CMD_FIX_POS);
            cyc(2000);
            wr(0, 32'h0000FFFF);
            cyc(600);
            chk_word(i[0] ? 32'h0000C000 : 32'h0000FFFF, 32'(cur_speed));
            wait_idle(30000);
            chk_word(32'h00000028, mcnt);
        end
        summarize();
    end
endmodule // tb
`default_nettype wire
